// >>> hdl/ccr_params.svh
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
// ----------------------------------------------------------------
// register map of the customer group
// ----------------------------------------------------------------
`define CCR_ADDR_W 11
`define CCR_SPACE_TOP 11'h7FF
`define CCR_OFF_IDENT 11'h000
`define CCR_OFF_CLKCTL 11'h004
`define CCR_CUST_TOP 11'h00F
`define CCR_BE_FULL 4'hF
// ----------------------------------------------------------------
// clock control fields
// ----------------------------------------------------------------
`define CCR_BIT_PLL_EN 0
`define CCR_BIT_SRC_SEL 1
`define CCR_BIT_PMUL_LO 2
`define CCR_BIT_PMUL_HI 3
`define CCR_BIT_RAM_DIV2 4
`define CCR_BIT_STOP 5
`define CCR_BIT_SDIV_LO 7
`define CCR_BIT_SDIV_HI 8
`define CCR_CLKCTL_RESET 32'h0000_0000
`define CCR_CLKCTL_WMASK 32'h0000_01BF
// ----------------------------------------------------------------
// multiplier factors, mode pins, protocol states, timing
// ----------------------------------------------------------------
`define CCR_MUL_CODE0 5'h14
`define CCR_MUL_CODE1 5'h10
`define CCR_MUL_CODE2 5'h0A
`define CCR_MUL_CODE3 5'h08
`define CCR_MODE_SERIAL_BIT 0
`define CCR_MODE_FSEL_LO 1
`define CCR_MODE_FSEL_HI 2
`define CCR_POCS_DEFAULT_CONFIG 6'h00
`define CCR_POCS_CONFIG 6'h0F
`define CCR_SWITCH_SETTLE 3'h4
`define CCR_STRAP_DELAY 2'h2
`endif

// >>> hdl/ccr_pkg.sv
package ccr_pkg;
   // host access as one bundle: strobe, direction, byte address, lanes, data
   typedef struct packed {
      logic req;
      logic we;
      logic [10:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } ccr_host_req_t;

   // host answer
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } ccr_host_rsp_t;

   // clock source switch sequence
   typedef enum logic [1:0] {
      CCR_SW_IDLE,
      CCR_SW_GATE,
      CCR_SW_SWAP,
      CCR_SW_OPEN
   } ccr_sw_state_t;
endpackage : ccr_pkg

// >>> hdl/ccr_clk_div.sv
`timescale 1ns/1ps
`include "ccr_params.svh"
// ----------------------------------------------------------------
// divider producing a clock enable, ratio 2**code
// ----------------------------------------------------------------
module ccr_clk_div #(
   parameter int CODE_W = 2,
   parameter int CNT_W = 3
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [CODE_W-1:0] div_code,
   input wire logic stop,
   output logic clk_en
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CODE_W-1:0] code_reg;
   logic stop_reg;
   logic [CNT_W-1:0] term;

   // last count of the running period
   assign term = CNT_W'((CNT_W'(1) << code_reg) - CNT_W'(1));

   // new ratio and stop only take effect at a period boundary, so no short pulse
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         code_reg <= '0;
         stop_reg <= 1'b0;
      end else if (cnt_reg == term) begin
         cnt_reg <= '0;
         code_reg <= div_code;
         stop_reg <= stop;
      end else begin
         cnt_reg <= CNT_W'(cnt_reg + CNT_W'(1));
      end
   end

   // one enable at the start of each period
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clk_en <= 1'b0;
      end else begin
         clk_en <= (cnt_reg == '0) && !stop_reg;
      end
   end
endmodule : ccr_clk_div

// >>> hdl/ccr_clk_switch.sv
`timescale 1ns/1ps
`include "ccr_params.svh"
// ----------------------------------------------------------------
// source select with gating around the change
// ----------------------------------------------------------------
module ccr_clk_switch (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sel_req,
   output logic sel_out,
   output logic gate_off
);
   ccr_pkg::ccr_sw_state_t state_reg;
   logic [2:0] wait_reg;

   // gate, settle, swap, settle, open: the mux never flips under a live clock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ccr_pkg::CCR_SW_IDLE;
         wait_reg <= 3'h0;
         sel_out <= 1'b0;
         gate_off <= 1'b0;
      end else begin
         case (state_reg)
            ccr_pkg::CCR_SW_IDLE: begin
               wait_reg <= 3'h0;
               if (sel_req != sel_out) begin
                  gate_off <= 1'b1;
                  state_reg <= ccr_pkg::CCR_SW_GATE;
               end
            end
            ccr_pkg::CCR_SW_GATE: begin
               wait_reg <= 3'(wait_reg + 3'h1);
               if (wait_reg == 3'(`CCR_SWITCH_SETTLE - 3'h1)) begin
                  state_reg <= ccr_pkg::CCR_SW_SWAP;
               end
            end
            ccr_pkg::CCR_SW_SWAP: begin
               sel_out <= sel_req;
               wait_reg <= 3'h0;
               state_reg <= ccr_pkg::CCR_SW_OPEN;
            end
            ccr_pkg::CCR_SW_OPEN: begin
               wait_reg <= 3'(wait_reg + 3'h1);
               if (wait_reg == 3'(`CCR_SWITCH_SETTLE - 3'h1)) begin
                  gate_off <= 1'b0;
                  state_reg <= ccr_pkg::CCR_SW_IDLE;
               end
            end
            default: begin
               state_reg <= ccr_pkg::CCR_SW_IDLE;
               gate_off <= 1'b0;
            end
         endcase
      end
   end
endmodule : ccr_clk_switch

// >>> hdl/ccr_top.sv
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_top #(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] REVISION = 8'h01, // arbitrary value
   parameter logic [7:0] DEVICE_NUMBER = 8'h3C, // arbitrary value
   parameter logic [7:0] IP_CODE = 8'h5A // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input ccr_pkg::ccr_host_req_t host_req,
   output ccr_pkg::ccr_host_rsp_t host_rsp,
   input wire logic [5:0] poc_state,
   input wire logic [2:0] mode_pins,
   output logic pll_enable,
   output logic [4:0] pll_factor,
   output logic sys_src_sel,
   output logic sys_clk_gate_off,
   output logic op_clk_en,
   output logic ram_clk_en
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0] clkctl_reg;
   logic [31:0] clkctl_next;
   logic [2:0] mode_meta_reg;
   logic [2:0] mode_sync_reg;
   logic [1:0] strap_cnt_reg;
   logic init_done_reg;
   logic full_word;
   logic cfg_state;
   logic wr_clkctl;
   logic [31:0] ident_word;
   logic [31:0] rd_word;

   // word match on the 11-bit byte address
   function automatic logic hit(input logic [10:0] addr, input logic [10:0] off);
      hit = (addr[10:2] == off[10:2]);
   endfunction : hit

   // multiplier code to factor
   function automatic logic [4:0] mul_factor(input logic [1:0] code);
      case (code)
         2'h0: mul_factor = `CCR_MUL_CODE0;
         2'h1: mul_factor = `CCR_MUL_CODE1;
         2'h2: mul_factor = `CCR_MUL_CODE2;
         default: mul_factor = `CCR_MUL_CODE3;
      endcase
   endfunction : mul_factor

   // ----------------------------------------------------------------
   // mode pin capture
   // ----------------------------------------------------------------
   // pins are asynchronous; two stages before anything reads them
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_meta_reg <= 3'h0;
         mode_sync_reg <= 3'h0;
      end else begin
         mode_meta_reg <= mode_pins;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   // straps are taken a few edges after release, once the synchroniser is full
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         strap_cnt_reg <= 2'h0;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         strap_cnt_reg <= 2'(strap_cnt_reg + 2'h1);
         if (strap_cnt_reg == `CCR_STRAP_DELAY) begin
            init_done_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // host access decode
   // ----------------------------------------------------------------
   assign full_word = (host_req.be == `CCR_BE_FULL);
   assign cfg_state = (poc_state == `CCR_POCS_DEFAULT_CONFIG) ||
                      (poc_state == `CCR_POCS_CONFIG);
   assign wr_clkctl = host_req.req && host_req.we && full_word && init_done_reg &&
                      cfg_state && hit(host_req.addr, `CCR_OFF_CLKCTL);
   assign ident_word = {MAKER_CODE, REVISION, DEVICE_NUMBER, IP_CODE};

   // read mux; words 0x8..0xF and all other offsets here read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit(host_req.addr, `CCR_OFF_IDENT)) begin
         rd_word = ident_word;
      end else if (hit(host_req.addr, `CCR_OFF_CLKCTL)) begin
         rd_word = clkctl_reg & `CCR_CLKCTL_WMASK;
      end
   end

   // ----------------------------------------------------------------
   // clock control register
   // ----------------------------------------------------------------
   // reserved bits are masked on the way in so they can never read back set
   always_comb begin
      clkctl_next = clkctl_reg;
      if (!init_done_reg && strap_cnt_reg == `CCR_STRAP_DELAY &&
          !mode_sync_reg[`CCR_MODE_SERIAL_BIT]) begin
         clkctl_next[`CCR_BIT_PLL_EN] = 1'b1;
         clkctl_next[`CCR_BIT_PMUL_HI:`CCR_BIT_PMUL_LO] =
            mode_sync_reg[`CCR_MODE_FSEL_HI:`CCR_MODE_FSEL_LO];
      end else if (wr_clkctl) begin
         clkctl_next = host_req.wdata & `CCR_CLKCTL_WMASK;
      end
   end

   // identity writes fall through the decode untouched
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clkctl_reg <= `CCR_CLKCTL_RESET;
      end else begin
         clkctl_reg <= clkctl_next;
      end
   end

   // one-cycle acknowledge, data held until the next read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         host_rsp.ack <= 1'b0;
         host_rsp.rdata <= 32'h0000_0000;
      end else begin
         host_rsp.ack <= host_req.req;
         if (host_req.req && !host_req.we) begin
            host_rsp.rdata <= rd_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // pll controls
   // ----------------------------------------------------------------
   // lock waiting is the host's job; the pll pin simply follows the bit
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pll_enable <= 1'b0;
         pll_factor <= `CCR_MUL_CODE0;
      end else begin
         pll_enable <= clkctl_reg[`CCR_BIT_PLL_EN];
         pll_factor <= mul_factor(clkctl_reg[`CCR_BIT_PMUL_HI:`CCR_BIT_PMUL_LO]);
      end
   end

   // ----------------------------------------------------------------
   // clock shaping
   // ----------------------------------------------------------------
   ccr_clk_switch u_switch (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sel_req(clkctl_reg[`CCR_BIT_SRC_SEL]),
      .sel_out(sys_src_sel),
      .gate_off(sys_clk_gate_off)
   );

   ccr_clk_div #(.CODE_W(2), .CNT_W(3)) u_op_div (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .div_code(clkctl_reg[`CCR_BIT_SDIV_HI:`CCR_BIT_SDIV_LO]),
      .stop(clkctl_reg[`CCR_BIT_STOP]),
      .clk_en(op_clk_en)
   );

   ccr_clk_div #(.CODE_W(1), .CNT_W(1)) u_ram_div (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .div_code(clkctl_reg[`CCR_BIT_RAM_DIV2]),
      .stop(clkctl_reg[`CCR_BIT_STOP]),
      .clk_en(ram_clk_en)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_partial_ignored;
      host_req.req && host_req.we && !full_word |=> $stable(clkctl_reg);
   endproperty
   a_partial_ignored: assert property (p_partial_ignored)
      else $error("partial-width write changed clock control");

   property p_upper_reads_zero;
      host_req.req && !host_req.we && host_req.addr[10:3] != 8'h00 |=>
         host_rsp.ack && host_rsp.rdata == 32'h0000_0000;
   endproperty
   a_upper_reads_zero: assert property (p_upper_reads_zero)
      else $error("address outside customer words returned data");

   property p_ident_read;
      host_req.req && !host_req.we && hit(host_req.addr, `CCR_OFF_IDENT) |=>
         host_rsp.rdata == {MAKER_CODE, REVISION, DEVICE_NUMBER, IP_CODE};
   endproperty
   a_ident_read: assert property (p_ident_read)
      else $error("identity word read back wrong");

   property p_ident_write;
      host_req.req && host_req.we && hit(host_req.addr, `CCR_OFF_IDENT) && init_done_reg
         |=> $stable(clkctl_reg);
   endproperty
   a_ident_write: assert property (p_ident_write)
      else $error("identity write disturbed clock control");

   property p_pll_follow;
      ##1 pll_enable == $past(clkctl_reg[`CCR_BIT_PLL_EN]);
   endproperty
   a_pll_follow: assert property (p_pll_follow)
      else $error("pll enable does not follow bit zero");

   property p_src_select;
      $changed(clkctl_reg[`CCR_BIT_SRC_SEL]) |->
         ##[1:12] sys_src_sel == clkctl_reg[`CCR_BIT_SRC_SEL];
   endproperty
   a_src_select: assert property (p_src_select)
      else $error("source select not applied in time");

   property p_mult;
      ##1 pll_factor == mul_factor($past(clkctl_reg[`CCR_BIT_PMUL_HI:`CCR_BIT_PMUL_LO]));
   endproperty
   a_mult: assert property (p_mult)
      else $error("pll factor wrong for multiplier code");

   property p_ram_half;
      (clkctl_reg[`CCR_BIT_RAM_DIV2] && !clkctl_reg[`CCR_BIT_STOP])[*4] ##0 ram_clk_en
         |=> !ram_clk_en;
   endproperty
   a_ram_half: assert property (p_ram_half)
      else $error("ram enable not halved");

   property p_stopped;
      clkctl_reg[`CCR_BIT_STOP][*8] |-> !op_clk_en && !ram_clk_en;
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("clock enables still running while stopped");

   property p_div8;
      (clkctl_reg[`CCR_BIT_SDIV_HI:`CCR_BIT_SDIV_LO] == 2'h3 &&
       !clkctl_reg[`CCR_BIT_STOP])[*8] ##0 op_clk_en |=> (!op_clk_en)[*7] ##1 op_clk_en;
   endproperty
   a_div8: assert property (p_div8)
      else $error("operating enable not one in eight");

   property p_reserved_zero;
      clkctl_reg[31:9] == 23'h0 && !clkctl_reg[6];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved clock control bits set");

   property p_locked_state;
      host_req.req && host_req.we && !cfg_state && init_done_reg |=> $stable(clkctl_reg);
   endproperty
   a_locked_state: assert property (p_locked_state)
      else $error("clock control changed outside configuration");

   property p_strap;
      $rose(init_done_reg) && !mode_sync_reg[`CCR_MODE_SERIAL_BIT] |->
         clkctl_reg[`CCR_BIT_PLL_EN] &&
         clkctl_reg[`CCR_BIT_PMUL_HI:`CCR_BIT_PMUL_LO] ==
            mode_sync_reg[`CCR_MODE_FSEL_HI:`CCR_MODE_FSEL_LO];
   endproperty
   a_strap: assert property (p_strap)
      else $error("serial mode straps not loaded");

   property p_gated_swap;
      $changed(sys_src_sel) |-> sys_clk_gate_off && $past(sys_clk_gate_off) ##1
         sys_clk_gate_off;
   endproperty
   a_gated_swap: assert property (p_gated_swap)
      else $error("source changed while clock ungated");

   c_cfg_write: cover property (wr_clkctl);
   c_src_to_pll: cover property ($rose(sys_src_sel));
   c_stop: cover property (clkctl_reg[`CCR_BIT_STOP][*8]);
   c_strap: cover property ($rose(init_done_reg) && clkctl_reg[`CCR_BIT_PLL_EN]);
endmodule : ccr_top

// >>> dv/ccr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host cpu model: word accesses on the register bundle
// ----------------------------------------------------------------
module ccr_host_model (
   input wire logic clk_sys,
   input wire logic rst_b,
   output ccr_pkg::ccr_host_req_t host_req,
   input ccr_pkg::ccr_host_rsp_t host_rsp
);
   // idle bus at time zero
   initial begin
      host_req = '0;
   end

   // one access: strobe for one cycle, then wait for the acknowledge edge;
   // the bench monitor checks what the answer carries
   task automatic access(input logic we, input logic [10:0] addr, input logic [3:0] be,
                         input logic [31:0] wdata);
      while (rst_b !== 1'b1) begin
         @(posedge clk_sys);
      end
      @(posedge clk_sys);
      host_req <= {1'b1, we, addr, be, wdata};
      @(posedge clk_sys);
      host_req.req <= 1'b0;
      // released lines must not keep showing the last value
      host_req.wdata <= ~wdata;
      host_req.addr <= ~addr;
      // a new request never overtakes an unanswered one; the bench timeout catches a hang
      while (host_rsp.ack !== 1'b1) begin
         @(posedge clk_sys);
      end
   endtask : access
endmodule : ccr_host_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------
   // constants, signals, scoreboard
   // ----------------------------------------------------------------
   localparam logic [7:0] ID_MAKER = 8'hA5; // arbitrary value
   localparam logic [7:0] ID_REV = 8'h01; // arbitrary value
   localparam logic [7:0] ID_DEV = 8'h3C; // arbitrary value
   localparam logic [7:0] ID_IP = 8'h5A; // arbitrary value
   localparam logic [31:0] ID_WORD = {ID_MAKER, ID_REV, ID_DEV, ID_IP};
   localparam int LOCK_CYC = 24000; // 600 us at 25 ns per cycle
   localparam int CYC_LIMIT = 40000;
   typedef struct {logic rd; logic [31:0] val;} ccr_note_t;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   ccr_pkg::ccr_host_req_t host_req;
   ccr_pkg::ccr_host_rsp_t host_rsp;
   logic [5:0] poc_state = 6'h00;
   logic [2:0] mode_pins = 3'h1;
   logic pll_enable;
   logic [4:0] pll_factor;
   logic sys_src_sel;
   logic sys_clk_gate_off;
   logic op_clk_en;
   logic ram_clk_en;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] lfsr = 32'h2CF1;
   ccr_note_t notes[$];
   logic [4:0] mul_tab [4] = '{5'h14, 5'h10, 5'h0A, 5'h08};

   // 40 mhz system clock
   always #12.5 clk_sys = ~clk_sys;

   ccr_top #(.MAKER_CODE(ID_MAKER), .REVISION(ID_REV), .DEVICE_NUMBER(ID_DEV),
             .IP_CODE(ID_IP)) u_ccr_top (
      .clk_sys(clk_sys), .rst_b(rst_b), .host_req(host_req), .host_rsp(host_rsp),
      .poc_state(poc_state), .mode_pins(mode_pins), .pll_enable(pll_enable),
      .pll_factor(pll_factor), .sys_src_sel(sys_src_sel),
      .sys_clk_gate_off(sys_clk_gate_off), .op_clk_en(op_clk_en), .ram_clk_en(ram_clk_en)
   );

   ccr_host_model u_ccr_host_model (
      .clk_sys(clk_sys), .rst_b(rst_b), .host_req(host_req), .host_rsp(host_rsp)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_end(string name);
      $display("test %s done", name);
   endtask : test_end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cycles(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cycles

   // writes are noted too, so every ack has a partner in the queue
   task automatic wr(logic [10:0] a, logic [31:0] d, logic [3:0] be = 4'hF);
      notes.push_back('{1'b0, 32'h0000_0000});
      u_ccr_host_model.access(1'b1, a, be, d);
   endtask : wr

   task automatic rd(logic [10:0] a, logic [31:0] exp);
      notes.push_back('{1'b1, exp});
      u_ccr_host_model.access(1'b0, a, 4'hF, 32'h0000_0000);
   endtask : rd

   task automatic do_reset(logic [2:0] pins);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      mode_pins <= pins;
      cycles(2);
      check("factor in reset", 32'(pll_factor), 32'h0000_0014);
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      cycles(6);
   endtask : do_reset

   // source swap must happen under the gate, gate reopens in bounded time
   task automatic wait_src(logic v);
      for (int i = 0; i < 20 && sys_src_sel !== v; i++) begin
         cycles(1);
      end
      check("src_sel", 32'(sys_src_sel), 32'(v));
      check("gate at swap", 32'(sys_clk_gate_off), 32'h1);
      for (int i = 0; i < 10 && sys_clk_gate_off !== 1'b0; i++) begin
         cycles(1);
      end
      check("gate reopen", 32'(sys_clk_gate_off), 32'h0);
   endtask : wait_src

   // divider changes land at period end, so let them settle before counting
   task automatic count_pulses(int exp_op, int exp_ram);
      int op;
      int ram;
      op = 0;
      ram = 0;
      cycles(16);
      repeat (32) begin
         cycles(1);
         op += (op_clk_en === 1'b1) ? 1 : 0;
         ram += (ram_clk_en === 1'b1) ? 1 : 0;
      end
      check("op pulses", op, exp_op);
      check("ram pulses", ram, exp_ram);
   endtask : count_pulses

   // ----------------------------------------------------------------
   // answer monitor and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      ccr_note_t n;
      if (host_rsp.ack === 1'b1) begin
         if (notes.size() == 0) begin
            check("stray ack", 32'h1, 32'h0);
         end else begin
            n = notes.pop_front();
            if (n.rd) check("rdata", host_rsp.rdata, n.val);
         end
      end
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == CYC_LIMIT) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset(3'h1);
      rd(11'h000, ID_WORD);
      // an all-ones ip code sends the host on to the core release word
      if (ID_IP == 8'hFF) begin
         rd(11'h3F0, 32'h0000_0000);
      end
      rd(11'h004, 32'h0000_0000);
      rd(11'h008, 32'h0000_0000);
      rd(11'h00C, 32'h0000_0000);
      rd(11'h7FC, 32'h0000_0000);
      lfsr = lfsr_next(lfsr);
      wr(11'h000, lfsr);
      rd(11'h000, ID_WORD);
      test_end("identity and map");
      // reserved ones are refused here on purpose
      wr(11'h004, 32'hFFFF_FFDC);
      rd(11'h004, 32'h0000_019C);
      wr(11'h004, 32'h0000_0000, 4'h7);
      rd(11'h004, 32'h0000_019C);
      lfsr = lfsr_next(lfsr);
      @(posedge clk_sys);
      poc_state <= (lfsr[5:0] == 6'h00 || lfsr[5:0] == 6'h0F) ? 6'h01 : lfsr[5:0];
      wr(11'h004, 32'h0000_0000);
      rd(11'h004, 32'h0000_019C);
      @(posedge clk_sys);
      poc_state <= 6'h0F;
      wr(11'h004, 32'h0000_0000);
      rd(11'h004, 32'h0000_0000);
      test_end("write refusals");
      for (int c = 0; c < 4; c++) begin
         wr(11'h004, 32'h0000_0001 | (32'(c) << 2));
         cycles(3);
         check("pll_enable", 32'(pll_enable), 32'h1);
         check("pll_factor", 32'(pll_factor), 32'(mul_tab[c]));
      end
      test_end("multiplier codes");
      // host waits lock before selecting the pll, deselects before stopping it
      cycles(LOCK_CYC);
      wr(11'h004, 32'h0000_000F);
      wait_src(1'b1);
      wr(11'h004, 32'h0000_000D);
      wait_src(1'b0);
      wr(11'h004, 32'h0000_000C);
      cycles(3);
      check("pll off", 32'(pll_enable), 32'h0);
      test_end("source switch");
      for (int c = 0; c < 4; c++) begin
         wr(11'h004, 32'(c) << 7);
         count_pulses(32 >> c, 32);
      end
      wr(11'h004, 32'h0000_0010);
      count_pulses(32, 16);
      wr(11'h004, 32'h0000_0030);
      count_pulses(0, 0);
      test_end("dividers and stop");
      // second reset in serial mode with random frequency pins
      lfsr = lfsr_next(lfsr);
      do_reset({lfsr[1:0], 1'b0});
      rd(11'h004, {28'h0000_000, lfsr[1:0], 2'h1});
      cycles(3);
      check("strap pll", 32'(pll_enable), 32'h1);
      check("strap factor", 32'(pll_factor), 32'(mul_tab[lfsr[1:0]]));
      check("open notes", 32'(notes.size()), 32'h0);
      test_end("serial straps");
      tally_and_finish();
   end
endmodule : tb
